/* File: inc/adccs_pkg.sv */
// Purpose: Shared constants and types for the conversion and chop sequencer.
// Assumes: One modulator tick per master clock rising edge.
// Notes: Command words are 16 bits; timing counts are in modulator ticks unless named otherwise.
package adccs_pkg;
   localparam int NUM_CH = 3;
   localparam int CH_W = 24;
   localparam int RES_W = NUM_CH * CH_W;
   // Oversampling ratio is 128 shifted left by the three-bit code.
   localparam logic [15:0] OSR_BASE = 16'h0080;
   // Fixed overhead ahead of the first chopped conversion after a restart (44 ticks).
   localparam logic [17:0] GC_OVERHEAD_TICKS = 18'h0_002C;
   localparam logic [17:0] ONE_TICK = 18'h0_0001;
   // Pin reset threshold, in master clock periods.
   localparam logic [15:0] RESET_LOW_MIN_MCLK = 16'h0800;
   localparam logic [15:0] CMD_STANDBY = 16'h0022;
   localparam logic [15:0] CMD_RESUME = 16'h0033;
   localparam logic [4:0] CMD_LAST_BIT = 5'h0F;
   localparam logic [4:0] CMD_BITS = 5'h10;
   // Response word bit positions.
   localparam int RESP_STBY_BIT = 15;
   localparam int RESP_CHOP_BIT = 14;
   localparam int RESP_POL_BIT = 13;
   localparam int RESP_NEW_BIT = 12;
   localparam logic [1:0] BIAS_OFF = 2'h0;
   localparam logic [1:0] BIAS_LOW = 2'h1;
   localparam logic [1:0] BIAS_FULL = 2'h2;
   localparam int LEVEL_SEL_HIRES_BIT = 1;
   localparam logic [2:0] CH_ALL_ON = 3'h7;

   typedef enum logic [2:0] {ST_CONT, ST_OVH, ST_DLY, ST_SMP, ST_STBY} adccs_state_t;

   typedef struct packed {
      logic mclk_s1, mclk_s2, mclk_d;
      logic sync_s1, sync_s2, sync_d;
      logic sclk_s1, sclk_s2, sclk_d;
      logic cs_s1, cs_s2;
      logic din_s1, din_s2;
      adccs_state_t st;
      logic [17:0] cnt;
      logic [2:0] osr_q;
      logic chop_q;
      logic pol, have_prev, filt_rst;
      logic [RES_W-1:0] prev, result;
      logic res_evt, ready_n, ready_pend;
      logic [15:0] sync_cnt;
      logic sync_fired, dev_rst, standby;
      logic [15:0] cmd;
      logic [4:0] bits;
      logic cmd_pulse;
      logic [15:0] tx;
      logic dout, dout_oe_n;
      logic phase_act, dc_act;
      logic [1:0] bias;
      logic [2:0] ch_en;
      logic ref_on;
   } adccs_reg_t;

   localparam adccs_reg_t RST_STATE = '{st: ST_CONT, ready_n: 1'b1, dout_oe_n: 1'b1,
      cs_s1: 1'b1, cs_s2: 1'b1, sync_s1: 1'b1, sync_s2: 1'b1, sync_d: 1'b1,
      default: '0};
endpackage

/* File: logic/adccs_seq.sv */
// Purpose: Conversion timing, chop sequencing, standby and serial command decode.
// Assumes: All pins are asynchronous to clk_i and pass two flip-flops first.
// Notes: Raw results are same-domain inputs valid when an internal conversion ends.
`timescale 1ns/100ps
module adccs_seq
   import adccs_pkg::*;
#(
   parameter logic [15:0] RESET_LOW_MIN = adccs_pkg::RESET_LOW_MIN_MCLK
)
(
   input wire logic clk_i, // System clock, 100 MHz.
   input wire logic sys_rst_i, // Asynchronous reset, active high.
   input wire logic master_clock_in_i, // Master clock pin; rising edges give modulator ticks.
   input wire logic sync_reset_n_i, // Sync/reset pin, active low.
   input wire logic sclk_i, // Serial clock pin.
   input wire logic cs_n_i, // Chip select pin, active low.
   input wire logic din_i, // Serial data in.
   input wire logic chop_enable_i, // Chop mode enable.
   input wire logic [3:0] chop_settle_delay_i, // Chop delay code.
   input wire logic [2:0] osr_code_i, // Oversampling ratio code.
   input wire logic [1:0] power_level_select_i, // Power mode field.
   input wire logic phase_cal_enable_i, // Requested phase calibration.
   input wire logic dc_test_select_i, // Requested DC test input.
   input wire logic [adccs_pkg::RES_W-1:0] raw_result_i, // Raw internal results.
   output logic [adccs_pkg::RES_W-1:0] result_o, // Published results.
   output logic result_ready_n_o, // Data ready, active low.
   output logic polarity_o, // Input polarity, high when reversed.
   output logic filter_reset_o, // Digital filter reset pulse.
   output logic phase_cal_active_o, // Effective phase calibration.
   output logic dc_test_active_o, // Effective DC test selection.
   output logic [1:0] bias_level_o, // Internal bias level.
   output logic [2:0] channels_enabled_o, // Channel enables.
   output logic reference_on_o, // Reference power.
   output logic standby_o, // Standby state.
   output logic device_reset_o, // Pin reset pulse.
   output logic dout_o, // Serial data out.
   output logic dout_oe_n_o // Serial data out enable, low drives.
);
   adccs_reg_t r, n;
   logic [RES_W-1:0] corr_w, avg_w;
   logic [15:0] osr_w;
   logic [17:0] osr3_w, dly_w;
   logic tick, sync_fall, sync_rise, sclk_rise, sclk_fall, restart, realign;

   assign osr_w = OSR_BASE << r.osr_q;
   assign osr3_w = {2'b00, osr_w} + {1'b0, osr_w, 1'b0};
   assign dly_w = ONE_TICK << ({1'b0, chop_settle_delay_i} + 5'h01);

   // Negating the reversed-polarity sample lets a plain mean cancel the offset.
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      logic [CH_W-1:0] raw, prv;
      logic [CH_W:0] sum;
      assign raw = raw_result_i[g*CH_W +: CH_W];
      assign prv = r.prev[g*CH_W +: CH_W];
      assign corr_w[g*CH_W +: CH_W] = r.pol ? (~raw + 24'h00_0001) : raw;
      assign sum = {corr_w[g*CH_W+CH_W-1], corr_w[g*CH_W +: CH_W]} + {prv[CH_W-1], prv};
      assign avg_w[g*CH_W +: CH_W] = sum[CH_W:1];
   end

   always_comb
   begin
      n = r;
      n.mclk_s1 = master_clock_in_i;
      n.mclk_s2 = r.mclk_s1;
      n.mclk_d = r.mclk_s2;
      n.sync_s1 = sync_reset_n_i;
      n.sync_s2 = r.sync_s1;
      n.sync_d = r.sync_s2;
      n.sclk_s1 = sclk_i;
      n.sclk_s2 = r.sclk_s1;
      n.sclk_d = r.sclk_s2;
      n.cs_s1 = cs_n_i;
      n.cs_s2 = r.cs_s1;
      n.din_s1 = din_i;
      n.din_s2 = r.din_s1;
      n.osr_q = osr_code_i;
      n.chop_q = chop_enable_i;
      n.res_evt = 1'b0;
      n.filt_rst = 1'b0;
      n.cmd_pulse = 1'b0;
      n.dev_rst = 1'b0;
      tick = r.mclk_s2 & ~r.mclk_d;
      sync_fall = ~r.sync_s2 & r.sync_d;
      sync_rise = r.sync_s2 & ~r.sync_d;
      sclk_rise = r.sclk_s2 & ~r.sclk_d;
      sclk_fall = ~r.sclk_s2 & r.sclk_d;

      // Except under a pin reset, a falling edge is produced even if ready is still low.
      if (r.ready_pend)
      begin
         n.ready_n = 1'b0;
         n.ready_pend = 1'b0;
      end
      if (r.res_evt)
      begin
         n.ready_n = 1'b1;
         n.ready_pend = 1'b1;
      end

      case (r.st)
         ST_CONT:
            if (tick)
            begin
               if (r.cnt == {2'b00, osr_w} - ONE_TICK)
               begin
                  n.cnt = '0;
                  n.result = raw_result_i;
                  n.res_evt = 1'b1;
               end
               else
                  n.cnt = r.cnt + ONE_TICK;
            end
         ST_OVH:
            if (tick)
            begin
               if (r.cnt == GC_OVERHEAD_TICKS - ONE_TICK)
               begin
                  n.cnt = '0;
                  n.st = ST_DLY;
               end
               else
                  n.cnt = r.cnt + ONE_TICK;
            end
         ST_DLY:
            if (tick)
            begin
               if (r.cnt == dly_w - ONE_TICK)
               begin
                  n.cnt = '0;
                  n.st = ST_SMP;
               end
               else
                  n.cnt = r.cnt + ONE_TICK;
            end
         ST_SMP:
            if (tick)
            begin
               if (r.cnt == osr3_w - ONE_TICK)
               begin
                  n.cnt = '0;
                  n.st = ST_DLY;
                  n.prev = corr_w;
                  n.have_prev = 1'b1;
                  n.pol = ~r.pol;
                  n.filt_rst = 1'b1;
                  if (r.have_prev)
                  begin
                     n.result = avg_w;
                     n.res_evt = 1'b1;
                  end
               end
               else
                  n.cnt = r.cnt + ONE_TICK;
            end
         ST_STBY:
            n.cnt = '0;
         default:
            n.st = ST_CONT;
      endcase

      // Sync pin: length of the low phase is measured in master clock periods.
      if (sync_fall)
      begin
         n.sync_cnt = '0;
         n.sync_fired = 1'b0;
      end
      else if (~r.sync_s2 && tick && r.sync_cnt != 16'hFFFF)
         n.sync_cnt = r.sync_cnt + 16'h0001;
      realign = sync_rise && !r.sync_fired && r.sync_cnt != 16'h0000 && !chop_enable_i;
      // A ratio change restarts in both modes, so the count never overruns a smaller ratio.
      restart = (chop_enable_i && sync_fall) || (r.osr_q != osr_code_i)
         || (chop_enable_i != r.chop_q) || realign;
      if (restart && !r.standby)
      begin
         n.cnt = '0;
         n.pol = 1'b0;
         n.have_prev = 1'b0;
         n.filt_rst = 1'b1;
         n.st = chop_enable_i ? ST_OVH : ST_CONT;
      end

      // Serial link: bit count and data out are held cleared, and the response word reloaded, while chip select is high.
      n.tx = '0;
      n.tx[RESP_STBY_BIT] = r.standby;
      n.tx[RESP_CHOP_BIT] = r.chop_q;
      n.tx[RESP_POL_BIT] = r.pol;
      n.tx[RESP_NEW_BIT] = ~r.ready_n;
      if (r.cs_s2)
      begin
         n.bits = '0;
         n.dout = 1'b0;
         n.dout_oe_n = 1'b1;
      end
      else
      begin
         n.tx = r.tx;
         n.dout_oe_n = 1'b0;
         if (sclk_rise)
         begin
            n.dout = r.tx[15];
            n.tx = {r.tx[14:0], 1'b0};
         end
         if (sclk_fall && r.bits != CMD_BITS)
         begin
            n.cmd = {r.cmd[14:0], r.din_s2};
            n.bits = r.bits + 5'h01;
            n.cmd_pulse = (r.bits == CMD_LAST_BIT);
         end
      end
      if (r.cmd_pulse && r.cmd == CMD_STANDBY)
      begin
         n.standby = 1'b1;
         n.st = ST_STBY;
      end
      else if (r.cmd_pulse && r.cmd == CMD_RESUME && r.standby)
      begin
         n.standby = 1'b0;
         n.cnt = '0;
         n.pol = 1'b0;
         n.have_prev = 1'b0;
         n.filt_rst = 1'b1;
         n.st = chop_enable_i ? ST_OVH : ST_CONT;
      end

      // Pin reset fires while the pin is still low, once per low phase.
      if (~r.sync_s2 && r.sync_cnt >= RESET_LOW_MIN && !r.sync_fired)
      begin
         n.sync_fired = 1'b1;
         n.dev_rst = 1'b1;
         n.standby = 1'b0;
         n.st = ST_CONT;
         n.cnt = '0;
         n.pol = 1'b0;
         n.have_prev = 1'b0;
         n.filt_rst = 1'b1;
         n.ready_n = 1'b1;
         n.ready_pend = 1'b0;
         n.res_evt = 1'b0;
      end

      n.phase_act = phase_cal_enable_i & ~chop_enable_i;
      n.dc_act = dc_test_select_i & ~chop_enable_i;
      if (n.standby)
         n.bias = BIAS_OFF;
      else
         n.bias = power_level_select_i[LEVEL_SEL_HIRES_BIT] ? BIAS_FULL : BIAS_LOW;
      n.ch_en = n.standby ? 3'h0 : CH_ALL_ON;
      n.ref_on = ~n.standby;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         r <= RST_STATE;
      else
         r <= n;
   end

   assign result_o = r.result;
   assign result_ready_n_o = r.ready_n;
   assign polarity_o = r.pol;
   assign filter_reset_o = r.filt_rst;
   assign phase_cal_active_o = r.phase_act;
   assign dc_test_active_o = r.dc_act;
   assign bias_level_o = r.bias;
   assign channels_enabled_o = r.ch_en;
   assign reference_on_o = r.ref_on;
   assign standby_o = r.standby;
   assign device_reset_o = r.dev_rst;
   assign dout_o = r.dout;
   assign dout_oe_n_o = r.dout_oe_n;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_phase_off;
      chop_enable_i |=> !phase_cal_active_o;
   endproperty
   a_phase_off: assert property (p_phase_off)
      else $error("Phase calibration active while chopping.");

   property p_dc_off;
      chop_enable_i |=> !dc_test_active_o;
   endproperty
   a_dc_off: assert property (p_dc_off)
      else $error("DC test input usable while chopping.");

   property p_stby_off;
      standby_o |-> (channels_enabled_o == 3'h0) && !reference_on_o && bias_level_o == BIAS_OFF;
   endproperty
   a_stby_off: assert property (p_stby_off)
      else $error("Channels or reference alive in standby.");

   property p_enter;
      r.cmd_pulse && r.cmd == CMD_STANDBY && !r.dev_rst |=> standby_o && r.st == ST_STBY;
   endproperty
   a_enter: assert property (p_enter)
      else $error("Standby command not obeyed.");

   property p_leave;
      r.cmd_pulse && r.cmd == CMD_RESUME && standby_o |=> !standby_o ##1 reference_on_o;
   endproperty
   a_leave: assert property (p_leave)
      else $error("Resume command not obeyed.");

   property p_ready_edge;
      r.res_evt && !r.dev_rst |=> result_ready_n_o ##1 !result_ready_n_o;
   endproperty
   a_ready_edge: assert property (p_ready_edge)
      else $error("No ready falling edge after a new result.");

   property p_swap_reset;
      $changed(polarity_o) |-> filter_reset_o;
   endproperty
   a_swap_reset: assert property (p_swap_reset)
      else $error("Polarity swapped without a filter reset.");

   property p_cs_idle;
      r.cs_s2 |=> dout_oe_n_o && r.bits == 5'h00;
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("Serial port active while deselected.");

   property p_cont_bound;
      r.st == ST_CONT |-> r.cnt < {2'b00, osr_w};
   endproperty
   a_cont_bound: assert property (p_cont_bound)
      else $error("Continuous count exceeds the oversampling ratio.");

   property p_no_swap_cont;
      !chop_enable_i && r.st == ST_CONT ##1 r.st == ST_CONT |-> !polarity_o;
   endproperty
   a_no_swap_cont: assert property (p_no_swap_cont)
      else $error("Polarity reversed outside chop mode.");
endmodule

/* File: verification/adccs_host.sv */
// Purpose: Host model for master clock, sync/reset pulses and SPI mode one frames.
// Assumes: Bench clock of 100 MHz; serial clock 80 ns, master clock 40 ns.
// Notes: A released data line is seen inverted from its last driven value.
`timescale 1ns/100ps
module adccs_host
(
   input wire logic clk_i, // Bench clock for pacing.
   input wire logic dout_i, // Serial data from device.
   input wire logic dout_oe_n_i, // Low while the device drives.
   output logic master_clock_in_o, // Master clock.
   output logic sync_reset_n_o, // Sync/reset, active low.
   output logic sclk_o, // Serial clock.
   output logic cs_n_o, // Chip select, active low.
   output logic din_o // Serial data to device.
);
   logic run = 1'b1;
   logic ph = 1'b0;
   logic last = 1'b0;
   logic line;
   initial
   begin
      master_clock_in_o = 1'b0;
      sync_reset_n_o = 1'b1;
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // The isolated supply is outside this block, so it counts as cleared before standby.
   always @(negedge clk_i)
   begin
      ph <= ~ph;
      if (run && ph)
         master_clock_in_o <= ~master_clock_in_o;
      if (!dout_oe_n_i)
         last <= dout_i;
   end
   assign line = dout_oe_n_i ? ~last : dout_i;
   task automatic frame(input logic [15:0] w, input logic sel, output logic [15:0] rx);
      @(negedge clk_i);
      cs_n_o = ~sel;
      repeat (8) @(negedge clk_i);
      for (int i = 15; i >= 0; i--)
      begin
         sclk_o = 1'b1;
         din_o = w[i];
         repeat (4) @(negedge clk_i);
         sclk_o = 1'b0;
         rx[i] = line;
         repeat (4) @(negedge clk_i);
      end
      cs_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic pulse(input int n);
      @(negedge clk_i);
      sync_reset_n_o = 1'b0;
      repeat (n * 4) @(negedge clk_i);
      sync_reset_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
endmodule

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the conversion and chop sequencer.
// Assumes: One modulator tick is four bench cycles.
// Notes: Restart timings allow a few cycles of synchroniser slack.
`timescale 1ns/100ps
module tb_top;
   import adccs_pkg::*;
   localparam logic [23:0] V = 24'h01_2345;
   localparam logic [23:0] OFS = 24'h00_0100;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic mclk, syn, sclk, cs_n, din, dout, oe_n;
   logic chop = 1'b0;
   logic [3:0] dly = 4'h0;
   logic [2:0] oversampling_ratio = 3'h0;
   logic [1:0] pwr = 2'h2;
   logic pcal = 1'b1;
   logic dct = 1'b1;
   logic [RES_W-1:0] raw, res;
   logic rdy, pol, frst, pc, dc, ref_on, stby, drst;
   logic [1:0] bias;
   logic [2:0] chs;
   logic [15:0] rx;
   int num_errors = 0;
   int check_count = 0;
   int n, nfr = 0, nrst = 0, a;
   // The reversed sample carries the signal with the opposite sign and the offset unchanged, so the mean cancels the offset.
   assign raw = {3{pol ? OFS - V : OFS + V}};
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      nfr <= nfr + int'(frst);
      nrst <= nrst + int'(drst);
   end
   adccs_host adccs_host_i (.clk_i(clk_i), .dout_i(dout), .dout_oe_n_i(oe_n),
      .master_clock_in_o(mclk), .sync_reset_n_o(syn), .sclk_o(sclk), .cs_n_o(cs_n),
      .din_o(din));
   adccs_seq #(.RESET_LOW_MIN(16'h0008)) adccs_seq_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .master_clock_in_i(mclk), .sync_reset_n_i(syn), .sclk_i(sclk), .cs_n_i(cs_n),
      .din_i(din), .chop_enable_i(chop), .chop_settle_delay_i(dly), .osr_code_i(oversampling_ratio),
      .power_level_select_i(pwr), .phase_cal_enable_i(pcal), .dc_test_select_i(dct),
      .raw_result_i(raw), .result_o(res), .result_ready_n_o(rdy), .polarity_o(pol),
      .filter_reset_o(frst), .phase_cal_active_o(pc), .dc_test_active_o(dc),
      .bias_level_o(bias), .channels_enabled_o(chs), .reference_on_o(ref_on),
      .standby_o(stby), .device_reset_o(drst), .dout_o(dout), .dout_oe_n_o(oe_n));
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wait_fall(input int lim, output int k);
      logic prev;
      prev = rdy;
      for (k = 1; k <= lim; k++)
      begin
         @(negedge clk_i);
         if (prev === 1'b1 && rdy === 1'b0)
            return;
         prev = rdy;
      end
      check(0, 1);
      end_sim();
   endtask
   task automatic t_cont();
      wait_fall(3000, n);
      wait_fall(3000, n);
      check(n, 512);
      check(res, {3{OFS + V}});
      a = nfr;
      wait_fall(3000, n);
      check(pol, 0);
      check(nfr - a, 0);
      a = nfr;
      adccs_host_i.pulse(2);
      check(nfr - a, 1);
      $display("Test continuous done");
   endtask
   task automatic t_chop(input logic [3:0] k, input logic [2:0] o, input logic by_sync);
      int e;
      int p;
      logic pl;
      @(negedge clk_i);
      chop = 1'b1;
      dly = k;
      if (by_sync)
      begin
         repeat (50) @(negedge clk_i);
         fork
            adccs_host_i.pulse(2);
            wait_fall(20000, n);
         join
      end
      else
      begin
         oversampling_ratio = o;
         wait_fall(20000, n);
      end
      p = (2 << k) + 3 * (128 << o);
      e = 4 * (44 + 2 * p);
      check(n > e - 14 && n < e + 14, 1);
      wait_fall(20000, n);
      a = nfr;
      pl = pol;
      wait_fall(20000, n);
      check(n, 4 * p);
      check(res, {3{V}});
      check(nfr - a, 1);
      check(pol, !pl);
      $display("Test chop done");
   endtask
   task automatic t_feat();
      for (int c = 0; c < 2; c++)
      begin
         @(negedge clk_i);
         chop = c[0];
         pwr = 2'(c + 1);
         repeat (5) @(negedge clk_i);
         check(pc, !chop);
         check(dc, !chop);
         check(bias, pwr[LEVEL_SEL_HIRES_BIT] ? BIAS_FULL : BIAS_LOW);
      end
      $display("Test features done");
   endtask
   task automatic t_stby();
      adccs_host_i.frame(CMD_STANDBY, 1'b1, rx);
      adccs_host_i.run = 1'b0;
      repeat (5) @(negedge clk_i);
      check(stby, 1);
      check({chs, ref_on, bias}, {3'h0, 1'b0, BIAS_OFF});
      adccs_host_i.frame(16'h0044, 1'b1, rx);
      check(stby, 1);
      check(rx[RESP_STBY_BIT], 1);
      adccs_host_i.frame(CMD_RESUME, 1'b0, rx);
      check(stby, 1);
      adccs_host_i.run = 1'b1;
      adccs_host_i.frame(CMD_RESUME, 1'b1, rx);
      repeat (5) @(negedge clk_i);
      check({stby, chs, ref_on}, {1'b0, CH_ALL_ON, 1'b1});
      $display("Test standby done");
   endtask
   task automatic t_pin();
      adccs_host_i.frame(CMD_STANDBY, 1'b1, rx);
      a = nrst;
      adccs_host_i.pulse(2);
      check(nrst - a, 0);
      check(stby, 1);
      adccs_host_i.pulse(12);
      check(nrst - a, 1);
      check(stby, 0);
      $display("Test pin reset done");
   endtask
   initial
   begin
      repeat (3) @(negedge clk_i);
      check({rdy, oe_n, stby}, 3'h6);
      sys_rst_i = 1'b0;
      repeat (5) @(negedge clk_i);
      t_cont();
      t_chop(4'h0, 3'h0, 1'b1);
      t_chop(4'h1, 3'h1, 1'b0);
      t_feat();
      t_stby();
      t_pin();
      end_sim();
   end
endmodule
